/* File: verilog/bmfa_defines.svh */
// bmfa_defines.svh: offsets, field positions and counts of the fetch arbiter
// assumes inclusion by bare name from the design file
// Overview of operation
// - pointer write starts autonomous instruction fetching
// - instruction fetches use memory space only
// - instruction is two words, 2x32 or 4x16
// - sixteen-bit fetch bit selects 16-bit fetches
// - fetch control-low bit 1 drives data/control low
// - fetch control-low bit 0 drives data/control high
// - bus width select picks 32 or 16-bit moves
// - io space select picks memory or io moves
// - fixed address select holds transfer address
// - request bus only for fetch or move
// - request, then drive bus after grant
// - chained request forwarded on own request
// - chained grant shows downstream master owns bus
// - simultaneous requests: device first, chain deferred
// - chain only: grant passed straight through
// - grant and chained request synchronised first
// - eight idle states before requesting again; two if a chained request is pending at burst end
// - two idle states after chained request
`ifndef BMFA_DEFINES_SVH
`define BMFA_DEFINES_SVH
`define BMFA_OFS_PTR    8'h00
`define BMFA_OFS_DCTL   8'h04
`define BMFA_OFS_TEST   8'h08
`define BMFA_OFS_MODE   8'h0C
`define BMFA_OFS_DADDR  8'h10
`define BMFA_OFS_CNT    8'h14
`define BMFA_OFS_STAT   8'h18
`define BMFA_OFS_INS0   8'h1C
`define BMFA_OFS_INS1   8'h20
`define BMFA_F_FETCH16  0
`define BMFA_F_DCLOW    0
`define BMFA_F_HALFW    0
`define BMFA_F_IOSP     1
`define BMFA_F_FIXA     2
`define BMFA_OP_MOVE    2'h0
`define BMFA_OP_HALT    2'h3
`define BMFA_GAP_FAIR   4'h8
`define BMFA_GAP_CHAIN  4'h2
`define BMFA_STEP16     32'h0000_0002
`define BMFA_STEP32     32'h0000_0004
`define BMFA_STEP_INS   32'h0000_0008
`endif

/* File: verilog/bmfa_pkg.sv */
// bmfa_pkg: types shared by the fetch arbiter
// uses nothing from bmfa_defines.svh; needs no include path
`default_nettype none
package bmfa_pkg;
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_REQ   = 3'b001,
    ST_ADS   = 3'b010,
    ST_WAIT  = 3'b011,
    ST_EXEC  = 3'b100,
    ST_CHAIN = 3'b101
  } bmfa_state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic        oe;
    logic        ads_n;
    logic        mio;
    logic        ctl_n;
    logic        w16;
  } bmfa_cyc_t;
endpackage
`default_nettype wire

/* File: verilog/bmfa_top.sv */
// bmfa_top: script fetch, block-move bus mastering and hold daisy chain
// assumes MCLK 20 MHz, bus ready input synchronous, grant/chain inputs async
//
// The implementer's own choices: the register addresses and the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "bmfa_defines.svh"
module bmfa_top
  import bmfa_pkg::*;
(
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic [7:0]  REG_ADDR,
  input  wire logic [31:0] REG_WDATA,
  input  wire logic        REG_WR,
  input  wire logic        REG_RD,
  output var  logic [31:0] REG_RDATA,
  output var  logic        HOLD_OUT,
  input  wire logic        BUS_GRANT_IN,
  input  wire logic        CHAINED_REQUEST_IN,
  output var  logic        CHAINED_GRANT_OUT,
  output var  logic [31:0] BUS_ADDR,
  output var  logic        BUS_ADDR_OE,
  output var  logic        BUS_ADS_N,
  output var  logic        BUS_MIO,
  output var  logic        DATA_CONTROL_N,
  output var  logic        BUS_W16,
  input  wire logic        BUS_READY_IN,
  input  wire logic [31:0] BUS_RDATA
);
  bmfa_state_t st_r, st_nxt;
  bmfa_cyc_t   cyc_r, cyc_nxt;
  logic [1:0]  sync1_r, sync2_r;
  logic        grant_s, chreq_s;
  logic [31:0] ptr_r, ptr_nxt, daddr_r, daddr_nxt, ins0_r, ins0_nxt, ins1_r, ins1_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [2:0]  dctl_r, dctl_nxt, test_r, test_nxt, mode_r, mode_nxt;
  logic        run_r, run_nxt, move_r, move_nxt, fetch_r, fetch_nxt;
  logic        hold_r, hold_nxt, chgnt_r, chgnt_nxt;
  logic [1:0]  beat_r, beat_nxt;
  logic [3:0]  gap_r, gap_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic        f16, last_beat;
  logic [31:0] dstep;

  // two flops per async input; only stage two is looked at
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= {CHAINED_REQUEST_IN, BUS_GRANT_IN};
      sync2_r <= sync1_r;
    end
  end
  assign grant_s = sync2_r[0];
  assign chreq_s = sync2_r[1];

  // burst shape helpers
  assign f16       = dctl_r[`BMFA_F_FETCH16];
  assign last_beat = (beat_r == (f16 ? 2'h3 : 2'h1));
  assign dstep     = mode_r[`BMFA_F_HALFW] ? `BMFA_STEP16 : `BMFA_STEP32;

  // next state of sequencer, bus cycle, registers and read port
  always_comb begin
    st_nxt    = st_r;
    cyc_nxt   = cyc_r;
    ptr_nxt   = ptr_r;
    daddr_nxt = daddr_r;
    ins0_nxt  = ins0_r;
    ins1_nxt  = ins1_r;
    cnt_nxt   = cnt_r;
    dctl_nxt  = dctl_r;
    test_nxt  = test_r;
    mode_nxt  = mode_r;
    run_nxt   = run_r;
    move_nxt  = move_r;
    fetch_nxt = fetch_r;
    hold_nxt  = hold_r;
    chgnt_nxt = chgnt_r;
    beat_nxt  = beat_r;
    gap_nxt   = (gap_r != 4'h0 && !hold_r) ? gap_r - 4'h1 : gap_r;
    rdata_nxt = 32'h0000_0000;
    case (st_r)
      ST_IDLE: begin
        // grant of the last tenure still in the synchroniser must clear first
        if (gap_r == 4'h0 && !grant_s) begin
          if (run_r) begin
            hold_nxt = 1'b1;     // own need wins over chain
            st_nxt   = ST_REQ;
          end else if (chreq_s) begin
            hold_nxt = 1'b1;     // forward downstream need
            st_nxt   = ST_CHAIN;
          end
        end
      end
      ST_REQ: begin
        if (grant_s) begin
          fetch_nxt     = !move_r;
          beat_nxt      = 2'h0;
          cyc_nxt.oe    = 1'b1;  // master now: drive address/control
          cyc_nxt.ads_n = 1'b0;
          cyc_nxt.addr  = move_r ? daddr_r : ptr_r;
          cyc_nxt.mio   = move_r ? !mode_r[`BMFA_F_IOSP] : 1'b1;
          cyc_nxt.ctl_n = move_r ? 1'b1 : !test_r[`BMFA_F_DCLOW];
          cyc_nxt.w16   = move_r ? mode_r[`BMFA_F_HALFW] : f16;
          st_nxt        = ST_ADS;
        end
      end
      ST_ADS: begin
        cyc_nxt.ads_n = 1'b1;
        st_nxt        = ST_WAIT;
      end
      ST_WAIT: begin
        if (BUS_READY_IN) begin
          if (fetch_r) begin
            // store word or half, low half first in 16-bit mode
            case ({f16, beat_r})
              3'b000:  ins0_nxt = BUS_RDATA;
              3'b001:  ins1_nxt = BUS_RDATA;
              3'b100:  ins0_nxt[15:0] = BUS_RDATA[15:0];
              3'b101:  ins0_nxt[31:16] = BUS_RDATA[15:0];
              3'b110:  ins1_nxt[15:0] = BUS_RDATA[15:0];
              3'b111:  ins1_nxt[31:16] = BUS_RDATA[15:0];
              default: ins0_nxt = ins0_r;
            endcase
            beat_nxt     = beat_r + 2'h1;
            cyc_nxt.addr = cyc_r.addr + (f16 ? `BMFA_STEP16 : `BMFA_STEP32);
            if (last_beat) begin
              ptr_nxt = ptr_r + `BMFA_STEP_INS; // keep fetching on our own
            end
          end else begin
            cnt_nxt = cnt_r - 16'h0001;
            if (!mode_r[`BMFA_F_FIXA]) begin
              daddr_nxt    = daddr_r + dstep;
              cyc_nxt.addr = cyc_r.addr + dstep;
            end
          end
          if ((fetch_r && last_beat) || (!fetch_r && cnt_r == 16'h0001)) begin
            hold_nxt   = 1'b0; // burst over: drop request, float bus
            cyc_nxt.oe = 1'b0;
            gap_nxt    = (chreq_s ? `BMFA_GAP_CHAIN : `BMFA_GAP_FAIR) - 4'h1;
            move_nxt   = 1'b0;
            st_nxt     = fetch_r ? ST_EXEC : ST_IDLE;
          end else begin
            cyc_nxt.ads_n = 1'b0;
            st_nxt        = ST_ADS;
          end
        end
      end
      ST_EXEC: begin
        // minimal decode: move loads address/count, halt stops the run
        if (ins0_r[31:30] == `BMFA_OP_MOVE) begin
          daddr_nxt = ins1_r;
          cnt_nxt   = ins0_r[15:0];
          move_nxt  = (ins0_r[15:0] != 16'h0000);
        end else if (ins0_r[31:30] == `BMFA_OP_HALT) begin
          run_nxt = 1'b0;
        end
        st_nxt = ST_IDLE;
      end
      ST_CHAIN: begin
        if (!chreq_s) begin
          hold_nxt  = 1'b0;
          chgnt_nxt = 1'b0;
          gap_nxt   = `BMFA_GAP_CHAIN - 4'h1;
          st_nxt    = ST_IDLE;
        end else if (grant_s && run_r && !chgnt_r) begin
          st_nxt = ST_REQ;          // grant not yet handed on: take it
        end else begin
          chgnt_nxt = grant_s;      // pass host grant through
        end
      end
      default: begin
        st_nxt = ST_IDLE;
      end
    endcase
    // software writes; pointer write (re)starts the run
    if (REG_WR) begin
      case (REG_ADDR)
        `BMFA_OFS_PTR: begin
          ptr_nxt = REG_WDATA;
          run_nxt = 1'b1;
        end
        `BMFA_OFS_DCTL: dctl_nxt = REG_WDATA[2:0];
        `BMFA_OFS_TEST: test_nxt = REG_WDATA[2:0];
        `BMFA_OFS_MODE: mode_nxt = REG_WDATA[2:0];
        default:        dctl_nxt = dctl_nxt;
      endcase
    end
    if (REG_RD) begin
      case (REG_ADDR)
        `BMFA_OFS_PTR:   rdata_nxt = ptr_r;
        `BMFA_OFS_DCTL:  rdata_nxt = {29'h0, dctl_r};
        `BMFA_OFS_TEST:  rdata_nxt = {29'h0, test_r};
        `BMFA_OFS_MODE:  rdata_nxt = {29'h0, mode_r};
        `BMFA_OFS_DADDR: rdata_nxt = daddr_r;
        `BMFA_OFS_CNT:   rdata_nxt = {16'h0, cnt_r};
        `BMFA_OFS_STAT:  rdata_nxt = {24'h0, st_r, run_r, move_r, hold_r, chgnt_r, grant_s};
        `BMFA_OFS_INS0:  rdata_nxt = ins0_r;
        `BMFA_OFS_INS1:  rdata_nxt = ins1_r;
        default:         rdata_nxt = 32'h0000_0000;
      endcase
    end
  end

  // state registers only
  always_ff @(posedge MCLK or posedge RST) begin
    if (RST) begin
      st_r    <= ST_IDLE;
      cyc_r   <= '{addr: 32'h0, oe: 1'b0, ads_n: 1'b1, mio: 1'b1, ctl_n: 1'b1, w16: 1'b0};
      ptr_r   <= 32'h0000_0000;
      daddr_r <= 32'h0000_0000;
      ins0_r  <= 32'h0000_0000;
      ins1_r  <= 32'h0000_0000;
      cnt_r   <= 16'h0000;
      dctl_r  <= 3'h0;
      test_r  <= 3'h0;
      mode_r  <= 3'h0;
      run_r   <= 1'b0;
      move_r  <= 1'b0;
      fetch_r <= 1'b0;
      hold_r  <= 1'b0;
      chgnt_r <= 1'b0;
      beat_r  <= 2'h0;
      gap_r   <= 4'h0;
      rdata_r <= 32'h0000_0000;
    end else begin
      st_r    <= st_nxt;
      cyc_r   <= cyc_nxt;
      ptr_r   <= ptr_nxt;
      daddr_r <= daddr_nxt;
      ins0_r  <= ins0_nxt;
      ins1_r  <= ins1_nxt;
      cnt_r   <= cnt_nxt;
      dctl_r  <= dctl_nxt;
      test_r  <= test_nxt;
      mode_r  <= mode_nxt;
      run_r   <= run_nxt;
      move_r  <= move_nxt;
      fetch_r <= fetch_nxt;
      hold_r  <= hold_nxt;
      chgnt_r <= chgnt_nxt;
      beat_r  <= beat_nxt;
      gap_r   <= gap_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // ports straight from flops
  assign REG_RDATA         = rdata_r;
  assign HOLD_OUT          = hold_r;
  assign CHAINED_GRANT_OUT = chgnt_r;
  assign BUS_ADDR          = cyc_r.addr;
  assign BUS_ADDR_OE       = cyc_r.oe;
  assign BUS_ADS_N         = cyc_r.ads_n;
  assign BUS_MIO           = cyc_r.mio;
  assign DATA_CONTROL_N    = cyc_r.ctl_n;
  assign BUS_W16           = cyc_r.w16;

  // checks on the driven side
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_low8;
    !hold_r [*8];
  endsequence
  sequence s_low2;
    !hold_r [*2];
  endsequence
  AST_FETCH_MEM: assert property (!cyc_r.ads_n && fetch_r |-> cyc_r.mio)
    else $error("fetch cycle not in memory space");
  AST_CTL_LOW: assert property (!cyc_r.ads_n && fetch_r && test_r[0] |-> !cyc_r.ctl_n)
    else $error("data/control not low on fetch");
  AST_CTL_HIGH: assert property (!cyc_r.ads_n && fetch_r && !test_r[0] |-> cyc_r.ctl_n)
    else $error("data/control not high on fetch");
  AST_SPACE: assert property (!cyc_r.ads_n && !fetch_r |-> cyc_r.mio == !mode_r[1])
    else $error("move space wrong");
  AST_WIDTH: assert property (!cyc_r.ads_n |-> cyc_r.w16 == (fetch_r ? f16 : mode_r[0]))
    else $error("transfer width wrong");
  AST_GRANT_ADS: assert property (st_r == ST_REQ && grant_s |=> !cyc_r.ads_n && cyc_r.oe)
    else $error("no cycle after grant");
  AST_GAP_FAIR: assert property ($fell(hold_r) && gap_r == 4'h7 |-> s_low8)
    else $error("fair gap too short");
  AST_GAP_CHAIN: assert property ($fell(hold_r) && gap_r == 4'h1 |-> s_low2)
    else $error("chain gap too short");
  AST_HOLD_BURST: assert property (st_r == ST_WAIT |-> hold_r && cyc_r.oe)
    else $error("request dropped mid burst");
  AST_CHGNT: assert property (chgnt_r |-> hold_r && !cyc_r.oe && $past(grant_s))
    else $error("chained grant without bus");
  sequence s_both_want;
    st_r == ST_CHAIN && chreq_s && grant_s && run_r && !chgnt_r;
  endsequence
  sequence s_took_bus;
    !chgnt_r && st_r == ST_REQ;
  endsequence
  sequence s_chain_only;
    st_r == ST_CHAIN && chreq_s && !run_r;
  endsequence
  sequence s_move_beat;
    st_r == ST_WAIT && BUS_READY_IN && !fetch_r;
  endsequence
  sequence s_last_fetch;
    st_r == ST_WAIT && BUS_READY_IN && fetch_r && last_beat;
  endsequence
  AST_FWD_REQ: assert property (st_r == ST_CHAIN |-> hold_r)
    else $error("chained request not forwarded");
  AST_CHAIN_DEFER: assert property (s_both_want |=> s_took_bus)
    else $error("chained grant not deferred");
  AST_CHAIN_PASS: assert property (s_chain_only |=> chgnt_r == $past(grant_s))
    else $error("grant not passed down the chain");
  AST_IDLE_QUIET: assert property (st_r == ST_IDLE && !run_r && !chreq_s |=> !hold_r)
    else $error("request without need");
  AST_FIX_ADDR: assert property (s_move_beat && mode_r[2] |=> $stable(cyc_r.addr))
    else $error("fixed address moved");
  AST_BURST_END: assert property (s_last_fetch |=> !hold_r && !cyc_r.oe)
    else $error("request kept after burst");
endmodule // bmfa_top
`default_nettype wire

/* File: verif/bmfa_host_model.sv */
// bmfa_host_model: host arbiter and script memory facing the fetch arbiter
// assumes one clock; one ready pulse answers each address strobe
`timescale 1ns/1ps
`default_nettype none
module bmfa_host_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic        hold,
  input  wire logic        ads_n,
  input  wire logic        oe,
  input  wire logic [31:0] addr,
  input  wire logic        w16,
  output var  logic        grant,
  output var  logic        ready,
  output var  logic [31:0] rdata
);
  logic [31:0] mem [0:255];
  logic [31:0] cyc_a;
  logic [2:0]  gcnt;
  logic [1:0]  wcnt;
  logic        busy;

  // quiet bus at time zero
  initial begin
    grant = 1'b0;
    ready = 1'b0;
    rdata = 32'h0;
    busy = 1'b0;
    gcnt = 3'h0;
    for (int i = 0; i < 256; i++) mem[i] = 32'h0;
  end

  // grant follows the request, later when slow, dropped with it
  always @(posedge clk) begin
    gcnt <= hold ? ((gcnt == 3'h7) ? gcnt : gcnt + 3'h1) : 3'h0;
    grant <= hold && (gcnt >= (slow ? 3'h3 : 3'h0));
  end

  // one wait state or three, then data with ready for one cycle
  always @(posedge clk) begin
    ready <= 1'b0;
    rdata <= ~rdata; // stale data never lingers on a released bus
    if (busy && wcnt == 2'h0) begin
      ready <= 1'b1;
      rdata <= (w16 && cyc_a[1]) ? {16'h0, mem[cyc_a[9:2]][31:16]} : mem[cyc_a[9:2]];
      busy <= 1'b0;
    end else if (busy) begin
      wcnt <= wcnt - 2'h1;
    end else if (!ads_n && oe) begin
      busy <= 1'b1;
      wcnt <= slow ? 2'h2 : 2'h0;
      cyc_a <= addr;
    end
  end
endmodule // bmfa_host_model
`default_nettype wire

/* File: verif/bmfa_top_tb_top.sv */
// bmfa_top_tb_top: register-driven tests of fetch, move and hold chaining
// assumes bmfa_host_model answers the bus; 50 ns clock
`timescale 1ns/1ps
`default_nettype none
module bmfa_top_tb_top;
  import bmfa_pkg::*;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        chreq = 1'b0;
  logic        slow = 1'b0;
  logic        chain_on = 1'b0;
  logic        armed = 1'b0;
  logic [31:0] rdata, bus_addr, bus_rdata, d;
  logic        hold, grant, cgo, oe, ads_n, mio, dcn, w16, ready;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          gap = 0;
  logic [34:0] seen[$];
  logic [34:0] expq[$];

  always #25 mclk = ~mclk;

  bmfa_top uut (.MCLK(mclk), .RST(rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata),
    .REG_WR(reg_wr), .REG_RD(reg_rd), .REG_RDATA(rdata), .HOLD_OUT(hold),
    .BUS_GRANT_IN(grant), .CHAINED_REQUEST_IN(chreq), .CHAINED_GRANT_OUT(cgo),
    .BUS_ADDR(bus_addr), .BUS_ADDR_OE(oe), .BUS_ADS_N(ads_n), .BUS_MIO(mio),
    .DATA_CONTROL_N(dcn), .BUS_W16(w16), .BUS_READY_IN(ready), .BUS_RDATA(bus_rdata));

  bmfa_host_model host (.clk(mclk), .slow(slow), .hold(hold), .ads_n(ads_n), .oe(oe),
    .addr(bus_addr), .w16(w16), .grant(grant), .ready(ready), .rdata(bus_rdata));

  task automatic chk(input logic [34:0] got, input logic [34:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 v = rdata;
  endtask

  // polls the run flag; bounded so a stuck run shows up as a mismatch
  task automatic wait_idle();
    int n;
    for (n = 0; n < 300; n++) begin
      rd(8'h18, d);
      if (d[4] === 1'b0) break;
    end
    chk(n < 300, 1);
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // every bus cycle is recorded; it must sit inside a granted request
  always @(posedge mclk) begin
    if (oe === 1'b1 && ads_n === 1'b0) begin
      seen.push_back({bus_addr, mio, dcn, w16});
      chk({hold, grant}, 2'b11);
    end
    if (cgo === 1'b1) chk(oe, 1'b0);
  end

  // low time of the request between two grants
  always @(posedge mclk) begin
    if (hold !== 1'b1) begin
      gap <= gap + 1;
    end else begin
      if (armed && gap > 0) chk(gap >= (chain_on ? 2 : 8), 1);
      gap <= 0;
      armed <= ~rst;
    end
  end

  initial begin
    repeat (50000) @(posedge mclk);
    n_fail++;
    end_of_test();
  end

  // main sequence: eight mode sets, idle, chain alone, chain against own need
  initial begin
    logic [2:0] m;
    int nf, fs, ms, k;
    // script loaded after the model has cleared its memory at time zero
    repeat (5) @(posedge mclk);
    host.mem[16] = 32'h0000_0003;
    host.mem[17] = 32'h0000_0100;
    host.mem[18] = 32'hC000_0000;
    rst <= 1'b0;
    @(posedge mclk);
    #1 chk({hold, cgo, oe, ads_n}, 4'h1);
    rd(8'h24, d);
    chk(d, 32'h0);
    for (int i = 0; i < 8; i++) begin
      m = i[2:0];
      slow <= m[1] ^ m[2];
      wr(8'h04, {31'h0, ~m[0]});
      wr(8'h08, {31'h0, m[1] ^ m[2]});
      wr(8'h0C, {29'h0, m});
      rd(8'h0C, d);
      chk(d, {29'h0, m});
      seen.delete();
      expq.delete();
      wr(8'h00, 32'h0000_0040);
      wait_idle();
      nf = m[0] ? 2 : 4;
      fs = m[0] ? 4 : 2;
      ms = m[0] ? 2 : 4;
      for (k = 0; k < nf; k++) expq.push_back({32'(32'h40 + k * fs), 1'b1, ~(m[1] ^ m[2]), ~m[0]});
      for (k = 0; k < 3; k++) expq.push_back({32'(32'h100 + (m[2] ? 0 : k * ms)), ~m[1], 1'b1, m[0]});
      for (k = 0; k < nf; k++) expq.push_back({32'(32'h48 + k * fs), 1'b1, ~(m[1] ^ m[2]), ~m[0]});
      chk(seen.size(), expq.size());
      for (k = 0; k < expq.size(); k++) chk(seen[k], expq[k]);
    end
    k = 0;
    repeat (40) begin
      @(posedge mclk);
      if (hold !== 1'b0) k++;
    end
    chk(k, 0);
    chain_on <= 1'b1;
    chreq <= 1'b1;
    for (k = 0; k < 20 && cgo !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    chk({hold, cgo, oe}, 3'b110);
    @(posedge mclk);
    chreq <= 1'b0;
    for (k = 0; k < 20 && hold !== 1'b0; k++) begin
      @(posedge mclk);
      #1;
    end
    chk({hold, cgo}, 2'b00);
    seen.delete();
    repeat (12) @(posedge mclk);
    chreq <= 1'b1;
    // pointer lands while the chain request waits for its grant
    repeat (3) @(posedge mclk);
    wr(8'h00, 32'h0000_0040);
    for (k = 0; k < 400 && cgo !== 1'b1; k++) begin
      @(posedge mclk);
      #1;
    end
    chk(seen.size() > 0 && cgo === 1'b1, 1);
    @(posedge mclk);
    chreq <= 1'b0;
    wait_idle();
    end_of_test();
  end
endmodule // bmfa_top_tb_top
`default_nettype wire
